// ### src/fwddec_top.sv
`timescale 1ns/100ps
module fwddec_top (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rstn,
    // Register port.
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_write,
    input wire logic i_reg_read,
    output logic [7:0] o_reg_rdata,
    // ISA master or DMA memory cycle in.
    input wire logic i_cyc_valid,
    input wire logic [31:0] i_cyc_addr,
    input wire logic i_cyc_write,
    input wire logic i_cyc_dma,
    // Routing decision out.
    output logic o_dec_valid,
    output logic o_dec_to_pci,
    output logic o_dec_keep_isa,
    output logic o_dec_hole_hit,
    output logic [31:0] o_dec_addr,
    output logic o_dec_write,
    output logic o_dec_dma,
    output fwddec_pkg::fwddec_reason_t o_dec_reason
);
    import fwddec_pkg::*;

    fwddec_cfg_if cfg ();

    logic [7:0] decode_control;
    logic [7:0] rom_enable;
    logic [7:0] hole_bottom_value;
    logic [7:0] hole_top_value;
    logic [7:0] utility_bus_chip_select_a;
    logic [COUNT_W-1:0] fwd_count;
    logic [COUNT_W-1:0] isa_count;
    logic [COUNT_W-1:0] next_fwd_count;
    logic [COUNT_W-1:0] next_isa_count;
    logic last_to_pci;
    logic last_hole_hit;
    fwddec_reason_t last_reason;
    logic [7:0] status;
    logic [7:0] next_rdata;
    logic fwd_event;
    logic isa_event;

    // The matcher sees the live registers, so a write in cycle N steers a
    // cycle presented in N+1; a cycle in the same cycle as the write still
    // decodes with the old value.
    assign cfg.decode_control = decode_control;
    assign cfg.rom_enable = rom_enable;
    assign cfg.hole_bottom_value = hole_bottom_value;
    assign cfg.hole_top_value = hole_top_value;
    assign cfg.bios_cs_enable = utility_bus_chip_select_a[BIOS_CS_ENABLE_BIT];
    assign cfg.addr = i_cyc_addr;

    fwddec_match u_match (
        .cfg(cfg)
    );

    // Decode control register.
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            decode_control <= RST_DECODE_CONTROL;
        end else if (i_reg_write && i_reg_addr == OFS_DECODE_CONTROL) begin
            decode_control <= i_reg_wdata;
        end
    end

    // ROM block enable register.
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            rom_enable <= RST_ROM_ENABLE;
        end else if (i_reg_write && i_reg_addr == OFS_ROM_ENABLE) begin
            rom_enable <= i_reg_wdata;
        end
    end

    // Hole bottom and top; the reset pair leaves the hole switched off.
    // Software is trusted to keep both at or above 1 MByte; no guard here.
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            hole_bottom_value <= RST_HOLE_BOTTOM;
            hole_top_value <= RST_HOLE_TOP;
        end else if (i_reg_write) begin
            if (i_reg_addr == OFS_HOLE_BOTTOM) begin
                hole_bottom_value <= i_reg_wdata;
            end
            if (i_reg_addr == OFS_HOLE_TOP) begin
                hole_top_value <= i_reg_wdata;
            end
        end
    end

    // Utility bus chip select register; only the BIOS enable acts here,
    // the other bits are stored so software reads back what it wrote.
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            utility_bus_chip_select_a <= RST_UTIL_CS_A;
        end else if (i_reg_write && i_reg_addr == OFS_UTIL_CS_A) begin
            utility_bus_chip_select_a <= i_reg_wdata;
        end
    end

    // Decision is registered so downstream sees stable data for one cycle.
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            o_dec_valid <= 1'b0;
            o_dec_to_pci <= 1'b0;
            o_dec_keep_isa <= 1'b0;
            o_dec_hole_hit <= 1'b0;
            o_dec_addr <= 32'h0000_0000;
            o_dec_write <= 1'b0;
            o_dec_dma <= 1'b0;
            o_dec_reason <= FWDDEC_RSN_NONE;
        end else begin
            o_dec_valid <= i_cyc_valid;
            o_dec_to_pci <= i_cyc_valid && cfg.to_pci;
            o_dec_keep_isa <= i_cyc_valid && !cfg.to_pci;
            o_dec_hole_hit <= i_cyc_valid && cfg.hole_hit;
            if (i_cyc_valid) begin
                o_dec_addr <= i_cyc_addr;
                o_dec_write <= i_cyc_write;
                o_dec_dma <= i_cyc_dma;
                o_dec_reason <= cfg.reason;
            end
        end
    end

    // Last decision, kept for the status register.
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            last_to_pci <= 1'b0;
            last_hole_hit <= 1'b0;
            last_reason <= FWDDEC_RSN_NONE;
        end else if (i_cyc_valid) begin
            last_to_pci <= cfg.to_pci;
            last_hole_hit <= cfg.hole_hit;
            last_reason <= cfg.reason;
        end
    end

    // Traffic counters. A write to either byte clears the counter, but a
    // cycle counted in that same cycle is not lost: it becomes the new one.
    assign fwd_event = i_cyc_valid && cfg.to_pci;
    assign isa_event = i_cyc_valid && !cfg.to_pci;

    always_comb begin
        next_fwd_count = fwd_count + COUNT_W'(fwd_event);
        if (i_reg_write && (i_reg_addr == OFS_FWD_COUNT_LO || i_reg_addr == OFS_FWD_COUNT_HI)) begin
            next_fwd_count = COUNT_W'(fwd_event);
        end
        next_isa_count = isa_count + COUNT_W'(isa_event);
        if (i_reg_write && (i_reg_addr == OFS_ISA_COUNT_LO || i_reg_addr == OFS_ISA_COUNT_HI)) begin
            next_isa_count = COUNT_W'(isa_event);
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            fwd_count <= '0;
            isa_count <= '0;
        end else begin
            fwd_count <= next_fwd_count;
            isa_count <= next_isa_count;
        end
    end

    // Status byte: hole state and the most recent decision.
    assign status = {cfg.hole_enabled, 2'b00, last_reason, last_hole_hit, last_to_pci};

    // Read multiplexer; unmapped offsets read as zero.
    always_comb begin
        case (i_reg_addr)
            OFS_DECODE_CONTROL: next_rdata = decode_control;
            OFS_ROM_ENABLE: next_rdata = rom_enable;
            OFS_HOLE_BOTTOM: next_rdata = hole_bottom_value;
            OFS_HOLE_TOP: next_rdata = hole_top_value;
            OFS_UTIL_CS_A: next_rdata = utility_bus_chip_select_a;
            OFS_STATUS: next_rdata = status;
            OFS_FWD_COUNT_LO: next_rdata = fwd_count[7:0];
            OFS_FWD_COUNT_HI: next_rdata = fwd_count[15:8];
            OFS_ISA_COUNT_LO: next_rdata = isa_count[7:0];
            OFS_ISA_COUNT_HI: next_rdata = isa_count[15:8];
            default: next_rdata = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe, zero otherwise.
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_read) begin
            o_reg_rdata <= next_rdata;
        end else begin
            o_reg_rdata <= 8'h00;
        end
    end

endmodule

// ### src/fwddec_pkg.sv
package fwddec_pkg;

    // Register offsets on the 8-bit configuration port.
    localparam logic [7:0] OFS_DECODE_CONTROL = 8'h48;
    localparam logic [7:0] OFS_ROM_ENABLE = 8'h49;
    localparam logic [7:0] OFS_HOLE_BOTTOM = 8'h4A;
    localparam logic [7:0] OFS_HOLE_TOP = 8'h4B;
    localparam logic [7:0] OFS_UTIL_CS_A = 8'h4E;
    localparam logic [7:0] OFS_STATUS = 8'h4F;
    localparam logic [7:0] OFS_FWD_COUNT_LO = 8'h50;
    localparam logic [7:0] OFS_FWD_COUNT_HI = 8'h51;
    localparam logic [7:0] OFS_ISA_COUNT_LO = 8'h52;
    localparam logic [7:0] OFS_ISA_COUNT_HI = 8'h53;

    // Reset values.
    localparam logic [7:0] RST_DECODE_CONTROL = 8'h01;
    localparam logic [7:0] RST_ROM_ENABLE = 8'h00;
    localparam logic [7:0] RST_HOLE_BOTTOM = 8'h10;
    localparam logic [7:0] RST_HOLE_TOP = 8'h0F;
    localparam logic [7:0] RST_UTIL_CS_A = 8'h00;

    // Field positions.
    localparam int TOM_MSB = 7;
    localparam int TOM_LSB = 4;
    localparam int LOW_BASE_BIT = 0;
    localparam int LOW_VIDEO_BIT = 2;
    localparam int LOW_BIOS_BIT = 3;
    localparam int LOW_EXT_BIT = 1;
    localparam int BIOS_CS_ENABLE_BIT = 6;
    localparam int COUNT_W = 16;

    // Address fields, in units of 64 KByte (A19..A16) below 1 MByte, except SEG_ROM_TOP3 (A19..A17) and MBYTE_ONE (MBytes, A23..A20).
    localparam logic [3:0] SEG_EXT_LO = 4'h8;
    localparam logic [3:0] SEG_EXT_HI = 4'h9;
    localparam logic [3:0] SEG_VIDEO_LO = 4'hA;
    localparam logic [3:0] SEG_VIDEO_HI = 4'hB;
    localparam logic [2:0] SEG_ROM_TOP3 = 3'h6;
    localparam logic [3:0] SEG_LOW_BIOS = 4'hE;
    localparam logic [3:0] MBYTE_ONE = 4'h1;

    // Why a cycle was routed the way it was.
    typedef enum logic [2:0] {
        FWDDEC_RSN_NONE,
        FWDDEC_RSN_LOW,
        FWDDEC_RSN_ROM,
        FWDDEC_RSN_TOM,
        FWDDEC_RSN_HOLE,
        FWDDEC_RSN_BIOS_CS
    } fwddec_reason_t;

endpackage

// ### src/fwddec_cfg_if.sv
`timescale 1ns/100ps
interface fwddec_cfg_if;
    import fwddec_pkg::*;

    logic [7:0] decode_control;
    logic [7:0] rom_enable;
    logic [7:0] hole_bottom_value;
    logic [7:0] hole_top_value;
    logic bios_cs_enable;
    logic [31:0] addr;
    logic to_pci;
    logic hole_hit;
    logic hole_enabled;
    fwddec_reason_t reason;

    // The register side supplies settings and address; the matcher answers.
    modport regs (
        output decode_control, rom_enable, hole_bottom_value, hole_top_value,
        output bios_cs_enable, addr,
        input to_pci, hole_hit, hole_enabled, reason
    );
    modport match (
        input decode_control, rom_enable, hole_bottom_value, hole_top_value,
        input bios_cs_enable, addr,
        output to_pci, hole_hit, hole_enabled, reason
    );
endinterface

// ### src/fwddec_match.sv
`timescale 1ns/100ps
module fwddec_match (
    // Settings in, routing decision out.
    fwddec_cfg_if.match cfg
);
    import fwddec_pkg::*;

    logic below_16m;
    logic below_1m;
    logic [3:0] seg;
    logic [3:0] tom_field;
    logic in_tom;
    logic low_hit;
    logic rom_hit;
    logic bios_block;

    assign below_16m = (cfg.addr[31:24] == 8'h00);
    assign below_1m = below_16m && (cfg.addr[23:20] == 4'h0);
    assign seg = cfg.addr[19:16];
    assign tom_field = cfg.decode_control[TOM_MSB:TOM_LSB];

    // Top of memory is field plus one MByte, so compare the MByte number directly.
    assign in_tom = below_16m && (cfg.addr[23:20] >= MBYTE_ONE)
        && (cfg.addr[23:20] <= tom_field);

    // Top below bottom turns the hole off.
    assign cfg.hole_enabled = (cfg.hole_top_value >= cfg.hole_bottom_value);

    // Both ends inclusive, the top covering its whole 64 KByte block.
    assign cfg.hole_hit = below_16m && cfg.hole_enabled
        && (cfg.addr[23:16] >= cfg.hole_bottom_value)
        && (cfg.addr[23:16] <= cfg.hole_top_value);

    // The BIOS chip select overrides the low BIOS enable.
    assign bios_block = below_1m && (seg == SEG_LOW_BIOS) && cfg.bios_cs_enable;

    // Fixed low-memory blocks.
    always_comb begin
        low_hit = 1'b0;
        if (below_1m) begin
            if (!cfg.addr[19]) begin
                low_hit = cfg.decode_control[LOW_BASE_BIT];
            end else if (seg == SEG_EXT_LO || seg == SEG_EXT_HI) begin
                low_hit = cfg.decode_control[LOW_EXT_BIT];
            end else if (seg == SEG_VIDEO_LO || seg == SEG_VIDEO_HI) begin
                low_hit = cfg.decode_control[LOW_VIDEO_BIT];
            end else if (seg == SEG_LOW_BIOS) begin
                low_hit = cfg.decode_control[LOW_BIOS_BIT] && !cfg.bios_cs_enable;
            end
        end
    end

    // Sixteen KByte ROM blocks: A16..A14 pick the enable bit.
    assign rom_hit = below_1m && (cfg.addr[19:17] == SEG_ROM_TOP3)
        && cfg.rom_enable[cfg.addr[16:14]];

    // Anything not claimed stays on ISA.
    always_comb begin
        cfg.to_pci = 1'b0;
        cfg.reason = FWDDEC_RSN_NONE;
        if (bios_block) begin
            cfg.reason = FWDDEC_RSN_BIOS_CS;
        end else if (low_hit) begin
            cfg.to_pci = 1'b1;
            cfg.reason = FWDDEC_RSN_LOW;
        end else if (rom_hit) begin
            cfg.to_pci = 1'b1;
            cfg.reason = FWDDEC_RSN_ROM;
        end else if (in_tom && cfg.hole_hit) begin
            cfg.reason = FWDDEC_RSN_HOLE;
        end else if (in_tom) begin
            cfg.to_pci = 1'b1;
            cfg.reason = FWDDEC_RSN_TOM;
        end
    end
endmodule

// ### test/fwddec_checker.sv
`timescale 1ns/100ps
module fwddec_checker
    import fwddec_pkg::*;
(
    // Clock, reset and register port.
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_reg_read,
    input wire logic [7:0] o_reg_rdata,
    // Cycle in and decision out.
    input wire logic i_cyc_valid,
    input wire logic [31:0] i_cyc_addr,
    input wire logic o_dec_valid,
    input wire logic o_dec_to_pci,
    input wire logic o_dec_keep_isa,
    input wire logic o_dec_hole_hit,
    input wire logic [31:0] o_dec_addr,
    input wire fwddec_reason_t o_dec_reason
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    // A decision is a request followed one cycle later by a valid pulse.
    sequence s_take;
        i_cyc_valid;
    endsequence
    sequence s_answer;
        o_dec_valid ##0 (o_dec_to_pci != o_dec_keep_isa);
    endsequence

    a_valid_follows: assert property (s_take |=> s_answer)
        else $error("decision missing after cycle");
    a_no_stray: assert property (!i_cyc_valid |=> !o_dec_valid)
        else $error("decision without cycle");
    a_idle_quiet: assert property (!o_dec_valid |-> !o_dec_to_pci && !o_dec_keep_isa)
        else $error("route flag outside decision");
    a_high_isa: assert property (i_cyc_valid && i_cyc_addr[31:24] != 8'h00 |=> o_dec_keep_isa && !o_dec_hole_hit)
        else $error("address above 16 MByte left ISA");
    a_top_bios: assert property (i_cyc_valid && i_cyc_addr[31:16] == 16'h000F |=> o_dec_keep_isa)
        else $error("upper BIOS segment left ISA");
    a_addr_copy: assert property (i_cyc_valid |=> o_dec_addr == $past(i_cyc_addr))
        else $error("decoded address differs");
    a_hole_route: assert property (o_dec_valid && o_dec_reason == FWDDEC_RSN_HOLE |-> o_dec_keep_isa)
        else $error("hole cycle forwarded");
    a_tom_route: assert property (o_dec_valid && o_dec_reason == FWDDEC_RSN_TOM |-> o_dec_to_pci)
        else $error("top of memory cycle kept on ISA");
    a_read_once: assert property (!i_reg_read |=> o_reg_rdata == 8'h00)
        else $error("read data outside its cycle");
endmodule

bind fwddec_top fwddec_checker u_checker (.i_clock(i_clock), .i_rstn(i_rstn),
    .i_reg_read(i_reg_read), .o_reg_rdata(o_reg_rdata), .i_cyc_valid(i_cyc_valid),
    .i_cyc_addr(i_cyc_addr), .o_dec_valid(o_dec_valid), .o_dec_to_pci(o_dec_to_pci),
    .o_dec_keep_isa(o_dec_keep_isa), .o_dec_hole_hit(o_dec_hole_hit),
    .o_dec_addr(o_dec_addr), .o_dec_reason(o_dec_reason));

// ### test/fwddec_isa_master.sv
`timescale 1ns/100ps
module fwddec_isa_master (
    // Bench request.
    input wire logic i_clock,
    input wire logic i_req,
    input wire logic [31:0] i_req_addr,
    // Memory cycle towards the decoder.
    output logic o_cyc_valid = 1'b0,
    output logic [31:0] o_cyc_addr = 32'h0,
    output logic o_cyc_write = 1'b0,
    output logic o_cyc_dma = 1'b0
);
    // One cycle per request; idle address lines never keep the old value.
    always @(posedge i_clock) begin
        o_cyc_valid <= i_req;
        o_cyc_addr <= i_req ? i_req_addr : ~o_cyc_addr;
        if (i_req) begin
            o_cyc_write <= ~o_cyc_write;
            o_cyc_dma <= o_cyc_write;
        end
    end
endmodule

// ### test/tb_isa_to_pci_memory_forward_decoder.sv
`timescale 1ns/100ps
module tb_isa_to_pci_memory_forward_decoder;
    import fwddec_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, wr_en = 1'b0, rd_en = 1'b0, req = 1'b0;
    logic cv, cw, cd, dv, dp, dk, dh, dw, dd;
    logic [7:0] ra = 8'h00, wd = 8'h00, rq;
    logic [31:0] qa = 32'h0, ca, da;
    fwddec_reason_t rs;
    int bad_count = 0, num_checks = 0;
    logic [31:0] lows [4] = '{32'h0, 32'h80000, 32'hA0000, 32'hE0000};

    fwddec_isa_master i_src (.i_clock(clk), .i_req(req), .i_req_addr(qa),
        .o_cyc_valid(cv), .o_cyc_addr(ca), .o_cyc_write(cw), .o_cyc_dma(cd));
    fwddec_top i_dut (.i_clock(clk), .i_rstn(rstn), .i_reg_addr(ra), .i_reg_wdata(wd),
        .i_reg_write(wr_en), .i_reg_read(rd_en), .o_reg_rdata(rq), .i_cyc_valid(cv),
        .i_cyc_addr(ca), .i_cyc_write(cw), .i_cyc_dma(cd), .o_dec_valid(dv),
        .o_dec_to_pci(dp), .o_dec_keep_isa(dk), .o_dec_hole_hit(dh), .o_dec_addr(da),
        .o_dec_write(dw), .o_dec_dma(dd), .o_dec_reason(rs));

    // Free-running 125 MHz clock.
    initial begin
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        ra <= a;
        wd <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just then.
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        ra <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk(rq, exp);
    endtask

    task automatic cyc(input logic [31:0] a, input logic pci, input logic hole);
        @(posedge clk);
        req <= 1'b1;
        qa <= a;
        @(posedge clk);
        req <= 1'b0;
        @(posedge clk);
        #1 chk(dv, 1'b1);
        chk(dp, pci);
        chk(dk, !pci);
        chk(dh, hole);
        chk(da, a);
        // The source holds its qualifiers until its next request, so compare live.
        chk(dw, cw);
        chk(dd, cd);
    endtask

    task automatic t_reset();
        rchk(OFS_DECODE_CONTROL, 8'h01);
        rchk(OFS_ROM_ENABLE, 8'h00);
        rchk(OFS_HOLE_BOTTOM, 8'h10);
        rchk(OFS_HOLE_TOP, 8'h0F);
        rchk(8'h60, 8'h00);
    endtask

    task automatic t_rw();
        for (int i = 0; i < 4; i++) begin
            wr(8'h48 + i[7:0], 8'hA5 ^ i[7:0]);
            rchk(8'h48 + i[7:0], 8'hA5 ^ i[7:0]);
        end
    endtask

    // Last byte below the top is forwarded, the first byte at the top is not.
    // With a 1 MByte top the byte below it is the upper BIOS, which stays on ISA.
    task automatic t_tom();
        for (int n = 0; n < 16; n++) begin
            wr(OFS_DECODE_CONTROL, {n[3:0], 4'h0});
            cyc(((n + 1) << 20) - 1, n != 0, 1'b0);
            cyc((n + 1) << 20, 1'b0, 1'b0);
        end
    endtask

    task automatic t_low();
        wr(OFS_UTIL_CS_A, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_DECODE_CONTROL, 8'h01 << i);
            for (int j = 0; j < 4; j++) begin
                cyc(lows[j] + 32'h1FF0, i == j, 1'b0);
            end
        end
        wr(OFS_UTIL_CS_A, 8'h40);
        cyc(32'hEFFFF, 1'b0, 1'b0);
    endtask

    task automatic t_rom();
        wr(OFS_DECODE_CONTROL, 8'h00);
        for (int k = 0; k < 8; k++) begin
            wr(OFS_ROM_ENABLE, 8'h01 << k);
            for (int j = 0; j < 8; j++) begin
                cyc(32'hC0000 + j * 32'h4000 + 32'h3FFF, k == j, 1'b0);
            end
        end
    endtask

    // A one-block hole at 15 MByte, then disabled, then one block at 1 MByte.
    task automatic t_hole();
        wr(OFS_DECODE_CONTROL, 8'hF0);
        wr(OFS_HOLE_BOTTOM, 8'hF0);
        wr(OFS_HOLE_TOP, 8'hF0);
        cyc(32'hF00000, 1'b0, 1'b1);
        cyc(32'hF0FFFF, 1'b0, 1'b1);
        cyc(32'hF10000, 1'b1, 1'b0);
        cyc(32'hEFFFFF, 1'b1, 1'b0);
        wr(OFS_HOLE_TOP, 8'hEF);
        cyc(32'hF00000, 1'b1, 1'b0);
        wr(OFS_HOLE_BOTTOM, 8'h10);
        wr(OFS_HOLE_TOP, 8'h10);
        cyc(32'h10FFFF, 1'b0, 1'b1);
        cyc(32'h110000, 1'b1, 1'b0);
        wr(OFS_HOLE_TOP, 8'hFF);
        cyc(32'h01100000, 1'b0, 1'b0);
    endtask

    // A write in the cycle of a decode only steers the following decode.
    task automatic t_edge();
        wr(OFS_HOLE_TOP, 8'h0F);
        wr(OFS_DECODE_CONTROL, 8'h10);
        @(posedge clk);
        req <= 1'b1;
        qa <= 32'h100000;
        @(posedge clk);
        req <= 1'b0;
        ra <= OFS_DECODE_CONTROL;
        wd <= 8'h00;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        #1 chk(dp, 1'b1);
        cyc(32'h100000, 1'b0, 1'b0);
    endtask

    // Counter clear, one forwarded cycle, then status and chip-select read-back.
    task automatic t_count();
        wr(OFS_DECODE_CONTROL, 8'h10);
        wr(OFS_FWD_COUNT_LO, 8'h00);
        cyc(32'h100000, 1'b1, 1'b0);
        chk(rs, FWDDEC_RSN_TOM);
        rchk(OFS_FWD_COUNT_LO, 8'h01);
        rchk(OFS_FWD_COUNT_HI, 8'h00);
        rchk(OFS_STATUS, 8'h0D);
        rchk(OFS_UTIL_CS_A, 8'h40);
    endtask

    task automatic conclude();
        if (bad_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // The whole sequence needs about 500 cycles; allow some fifty times that.
    initial begin
        #200000;
        bad_count++;
        conclude();
    end

    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_rw();
        t_tom();
        t_low();
        t_rom();
        t_hole();
        t_edge();
        t_count();
        conclude();
    end
endmodule
